// >>> inc/pmcs_cfg.svh
// Encodings, field positions, reset values and timing counts of the switch
`ifndef PMCS_CFG_SVH
`define PMCS_CFG_SVH

// Clock source select encodings
`define PMCS_SRC_RC0       2'b00
`define PMCS_SRC_SEC       2'b01
`define PMCS_SRC_PRI       2'b10
`define PMCS_SRC_RC        2'b11

// Oscillator control status image field positions
`define PMCS_IDLE_SEL_BIT  7
`define PMCS_PRIMARY_RUN_MODE_BIT   3
`define PMCS_SCS_HI_BIT    1
`define PMCS_SCS_LO_BIT    0

// Secondary timer control status image field position
`define PMCS_SEC_ACT_BIT   6

// Reset values
`define PMCS_RST_STATUS    8'h00

// Switch timing in source ticks
`define PMCS_OLD_TICKS     3'd2
`define PMCS_NEW_TICKS     3'd3

// Clock rate and CPU ready delay
`define PMCS_CLK_MHZ       50
`define PMCS_CPU_READY_NS  1000
`define PMCS_CPU_READY_CYC ((`PMCS_CPU_READY_NS * `PMCS_CLK_MHZ) / 1000)

`endif

// >>> inc/pmcs_pkg.sv
// Types shared by the power mode clock switch
package pmcs_pkg;

  typedef enum logic [2:0] {
    PMCS_RUN    = 3'h0,
    PMCS_SW_OLD = 3'h1,
    PMCS_SW_NEW = 3'h3,
    PMCS_IDLE   = 3'h2,
    PMCS_SLEEP  = 3'h6,
    PMCS_WAKE   = 3'h7,
    PMCS_DELAY  = 3'h5,
    PMCS_SPARE  = 3'h4
  } pmcs_state_t;

  typedef logic [1:0] pmcs_src_t;

endpackage

// >>> logic/pmcs_tick_sel.sv
// Picks the ticks of the old and new clock sources and the readiness of the new one
`timescale 1ns/10ps
`include "pmcs_cfg.svh"
module pmcs_tick_sel
  import pmcs_pkg::*;
(
  // Source ticks and readiness
  input  wire logic      i_pri_tick,
  input  wire logic      i_sec_tick,
  input  wire logic      i_rc_tick,
  input  wire logic      i_pri_ready,
  input  wire logic      i_sec_running,
  // Selection
  input  wire pmcs_src_t i_old_src,
  input  wire pmcs_src_t i_new_src,
  // Selected
  output logic           o_old_tick,
  output logic           o_new_tick,
  output logic           o_new_ready
);

  function automatic logic pick(input pmcs_src_t s, input logic p,
                                input logic c, input logic r);
    case (s)
      `PMCS_SRC_PRI: pick = p;
      `PMCS_SRC_SEC: pick = c;
      default:       pick = r;
    endcase
  endfunction

  always_comb begin
    o_old_tick  = pick(i_old_src, i_pri_tick, i_sec_tick, i_rc_tick);
    o_new_tick  = pick(i_new_src, i_pri_tick, i_sec_tick, i_rc_tick);
    // The RC source is taken as always ready, whatever its enable
    o_new_ready = pick(i_new_src, i_pri_ready, i_sec_running, 1'b1);
  end

endmodule

// >>> logic/pmcs_ready_delay.sv
// Counts the CPU ready delay after a wake event
`timescale 1ns/10ps
`include "pmcs_cfg.svh"
module pmcs_ready_delay #(
  parameter int CYCLES = `PMCS_CPU_READY_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_start,
  output logic      o_done
);

  localparam int W = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } pmcs_dly_t;

  pmcs_dly_t r;
  pmcs_dly_t next_r;

  always_comb begin
    next_r = r;
    if (i_start) begin
      next_r.busy = 1'b1;
      next_r.cnt  = '0;
    end else if (r.busy) begin
      // Count parks at its end value, so it never wraps
      if (r.cnt >= W'(CYCLES - 1)) begin
        next_r.busy = 1'b0;
      end else begin
        next_r.cnt = r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Done read from the count saves the edge a registered flag would cost
  assign o_done = r.busy && (r.cnt >= W'(CYCLES - 1));

endmodule

// >>> logic/pmcs_switch.sv
// Power mode and clock source switching controller
`timescale 1ns/10ps
`include "pmcs_cfg.svh"
module pmcs_switch
  import pmcs_pkg::*;
#(
  parameter int CPU_READY_CYC = `PMCS_CPU_READY_CYC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Software control bits
  input  wire logic [1:0] i_clock_source_select,
  input  wire logic       i_idle_select,
  input  wire logic       i_secondary_osc_enable,
  input  wire logic       i_sleep,
  // Configuration
  input  wire logic       i_two_speed_en,
  input  wire logic       i_fail_safe_en,
  input  wire logic       i_watchdog_en,
  // Wake events
  input  wire logic       i_wake_irq,
  input  wire logic       i_watchdog_timeout,
  // Oscillator ticks and readiness
  input  wire logic       i_pri_tick,
  input  wire logic       i_sec_tick,
  input  wire logic       i_rc_tick,
  input  wire logic       i_pri_ready,
  input  wire logic       i_sec_running,
  // Gated clock enables
  output logic            o_cpu_tick,
  output logic            o_periph_tick,
  // Oscillator enables
  output logic            o_pri_osc_en,
  output logic            o_sec_osc_en,
  output logic            o_rc_osc_en,
  // Status
  output logic            o_primary_clock_running,
  output logic            o_secondary_clock_active,
  output logic [7:0]      o_osc_status,
  output logic [7:0]      o_timer_status,
  output pmcs_state_t     o_state
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    pmcs_state_t state;
    pmcs_src_t   cur_src;
    pmcs_src_t   new_src;
    logic [2:0]  cnt;
    logic        refused;
    logic [1:0]  scs_prev;
    logic        pri_flag;
    logic        sec_flag;
    logic        cpu_tick;
    logic        per_tick;
    logic        pri_en;
    logic        rc_en;
    logic        sec_en;
    logic        delay_go;
    logic [7:0]  osc_stat;
    logic [7:0]  tmr_stat;
  } pmcs_regs_t;

  pmcs_regs_t r;
  pmcs_regs_t next_r;

  logic      old_tick;
  logic      new_tick;
  logic      new_ready;
  logic      delay_done;
  logic      wake;
  pmcs_src_t target;

  ////////////////////////////////////////////////////////////////////////////

  pmcs_tick_sel u_tick_sel (
    .i_pri_tick    (i_pri_tick),
    .i_sec_tick    (i_sec_tick),
    .i_rc_tick     (i_rc_tick),
    .i_pri_ready   (i_pri_ready),
    .i_sec_running (i_sec_running),
    .i_old_src     (r.cur_src),
    .i_new_src     (r.new_src),
    .o_old_tick    (old_tick),
    .o_new_tick    (new_tick),
    .o_new_ready   (new_ready)
  );

  pmcs_ready_delay #(
    .CYCLES (CPU_READY_CYC)
  ) u_ready_delay (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (r.delay_go),
    .o_done  (delay_done)
  );

  ////////////////////////////////////////////////////////////////////////////

  function automatic pmcs_src_t norm_src(input logic [1:0] s);
    // A cleared select also means the internal RC source
    norm_src = (s == `PMCS_SRC_RC0) ? `PMCS_SRC_RC : s;
  endfunction

  function automatic logic src_tick(input pmcs_src_t s);
    case (s)
      `PMCS_SRC_PRI: src_tick = i_pri_tick;
      `PMCS_SRC_SEC: src_tick = i_sec_tick;
      default:       src_tick = i_rc_tick;
    endcase
  endfunction

  assign target = norm_src(i_clock_source_select);
  assign wake   = i_wake_irq | i_watchdog_timeout;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_r          = r;
    next_r.cpu_tick = 1'b0;
    next_r.per_tick = 1'b0;
    next_r.delay_go = 1'b0;
    next_r.scs_prev = i_clock_source_select;

    // Refusal holds only while the select stays where it was written
    if (i_clock_source_select != r.scs_prev) begin
      next_r.refused = (target == `PMCS_SRC_SEC) &&
                       !i_secondary_osc_enable;
    end

    case (r.state)
      PMCS_RUN: begin
        next_r.cpu_tick = src_tick(r.cur_src);
        next_r.per_tick = src_tick(r.cur_src);
        if (i_sleep) begin
          if (i_idle_select) begin
            next_r.state = PMCS_IDLE;
          end else begin
            next_r.state    = PMCS_SLEEP;
            next_r.pri_flag = 1'b0;
            next_r.sec_flag = 1'b0;
          end
        end else if (target != r.cur_src && !next_r.refused) begin
          // Old source keeps clocking while primary warms up
          if (target != `PMCS_SRC_PRI || i_pri_ready) begin
            next_r.state   = PMCS_SW_OLD;
            next_r.new_src = target;
            next_r.cnt     = '0;
          end
        end
      end

      PMCS_SW_OLD: begin
        // Clocks stop on a tick boundary, so no runt pulse escapes
        if (old_tick) begin
          next_r.cnt = r.cnt + 3'd1;
          if (r.cnt + 3'd1 >= `PMCS_OLD_TICKS) begin
            next_r.state = PMCS_SW_NEW;
            next_r.cnt   = '0;
          end
        end
      end

      PMCS_SW_NEW: begin
        // Device clocks held off until the new source oscillates
        if (new_ready && new_tick) begin
          next_r.cnt = r.cnt + 3'd1;
          if (r.cnt + 3'd1 >= `PMCS_NEW_TICKS) begin
            next_r.state    = PMCS_RUN;
            next_r.cur_src  = r.new_src;
            next_r.pri_flag = (r.new_src == `PMCS_SRC_PRI);
            next_r.sec_flag = (r.new_src == `PMCS_SRC_SEC);
          end
        end
      end

      PMCS_IDLE: begin
        next_r.per_tick = src_tick(r.cur_src);
        if (wake) begin
          next_r.state    = PMCS_DELAY;
          next_r.delay_go = 1'b1;
        end
      end

      PMCS_SLEEP: begin
        // CPU and peripheral ticks stay off; the select is read again only on wake
        if (wake) begin
          next_r.state = PMCS_WAKE;
        end
      end

      PMCS_WAKE: begin
        if (i_two_speed_en || i_fail_safe_en) begin
          // Run from RC now; the run state switches when primary is ready
          next_r.state    = PMCS_DELAY;
          next_r.delay_go = 1'b1;
          next_r.cur_src  = `PMCS_SRC_RC;
          next_r.pri_flag = 1'b0;
          next_r.sec_flag = 1'b0;
        end else begin
          // Select may have moved during Sleep, so settle on it first
          next_r.new_src = target;
          if (new_ready && r.new_src == target) begin
            next_r.state    = PMCS_DELAY;
            next_r.delay_go = 1'b1;
            next_r.cur_src  = target;
            next_r.pri_flag = (target == `PMCS_SRC_PRI);
            next_r.sec_flag = (target == `PMCS_SRC_SEC);
          end
        end
      end

      PMCS_DELAY: begin
        next_r.per_tick = src_tick(r.cur_src);
        if (delay_done) begin
          next_r.state = PMCS_RUN;
        end
      end

      default: begin
        next_r.state = PMCS_RUN;
      end
    endcase

    // Primary stays on only where it clocks, warms up, or idles
    next_r.pri_en = (next_r.state != PMCS_SLEEP) &&
                    (next_r.cur_src == `PMCS_SRC_PRI ||
                     target == `PMCS_SRC_PRI);
    next_r.sec_en = i_secondary_osc_enable;
    next_r.rc_en  = i_watchdog_en || i_fail_safe_en ||
                    (next_r.state != PMCS_SLEEP &&
                     next_r.cur_src == `PMCS_SRC_RC);

    // Select bits echo software only; hardware never writes them
    next_r.osc_stat                    = `PMCS_RST_STATUS;
    next_r.osc_stat[`PMCS_IDLE_SEL_BIT] = i_idle_select;
    next_r.osc_stat[`PMCS_PRIMARY_RUN_MODE_BIT]  = next_r.pri_flag;
    next_r.osc_stat[`PMCS_SCS_HI_BIT]   =
      i_clock_source_select[1];
    next_r.osc_stat[`PMCS_SCS_LO_BIT]   =
      i_clock_source_select[0];
    next_r.tmr_stat                    = `PMCS_RST_STATUS;
    next_r.tmr_stat[`PMCS_SEC_ACT_BIT]  = next_r.sec_flag;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r          <= '0;
      r.state    <= PMCS_RUN;
      r.cur_src  <= i_two_speed_en ? `PMCS_SRC_RC : `PMCS_SRC_PRI;
      r.new_src  <= `PMCS_SRC_PRI;
      r.pri_flag <= !i_two_speed_en;
      r.pri_en   <= 1'b1;
      r.rc_en    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign o_cpu_tick               = r.cpu_tick;
  assign o_periph_tick            = r.per_tick;
  assign o_pri_osc_en             = r.pri_en;
  assign o_sec_osc_en             = r.sec_en;
  assign o_rc_osc_en              = r.rc_en;
  assign o_primary_clock_running  = r.pri_flag;
  assign o_secondary_clock_active = r.sec_flag;
  assign o_osc_status             = r.osc_stat;
  assign o_timer_status           = r.tmr_stat;
  assign o_state                  = r.state;

endmodule

// >>> dv/pmcs_switch_monitor.sv
// Port checker for the power mode clock switch
`timescale 1ns/10ps
module pmcs_switch_monitor
  import pmcs_pkg::*;
#(
  parameter int CPU_READY_CYC = 2
) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // Controls
  input wire logic [1:0]  i_clock_source_select,
  input wire logic        i_idle_select,
  input wire logic        i_sleep,
  // Results
  input wire logic        o_cpu_tick,
  input wire logic        o_pri_osc_en,
  input wire logic        o_primary_clock_running,
  input wire logic        o_secondary_clock_active,
  input wire logic [7:0]  o_osc_status,
  input wire logic [7:0]  o_timer_status,
  input wire pmcs_state_t o_state
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Images lag reset release by one edge
  int unsigned dly;
  always_ff @(posedge i_clk)
    dly <= (o_state == PMCS_DELAY && !i_rst) ? dly + 1 : 0;
  ////////////////////////////////////////
  property p_pri;
    !$past(i_rst) |-> o_osc_status[3] == o_primary_clock_running;
  endproperty
  a_pri: assert property (p_pri) else $error("bad osc image");
  property p_sec;
    !$past(i_rst) |-> o_timer_status[6] == o_secondary_clock_active;
  endproperty
  a_sec: assert property (p_sec) else $error("bad timer image");
  property p_sel;
    !$past(i_rst) |-> o_osc_status[7] == $past(i_idle_select)
      && o_osc_status[1:0] == $past(i_clock_source_select);
  endproperty
  a_sel: assert property (p_sel) else $error("bad select echo");
  property p_one;
    !(o_primary_clock_running && o_secondary_clock_active);
  endproperty
  a_one: assert property (p_one) else $error("two flags set");
  property p_slp;
    i_sleep && !i_idle_select && o_state == PMCS_RUN |=> o_state == PMCS_SLEEP
      && !o_primary_clock_running && !o_secondary_clock_active && !o_pri_osc_en;
  endproperty
  a_slp: assert property (p_slp) else $error("bad sleep entry");
  property p_idl;
    i_sleep && i_idle_select && o_state == PMCS_RUN |=> o_state == PMCS_IDLE
      && $stable(o_primary_clock_running) && $stable(o_secondary_clock_active);
  endproperty
  a_idl: assert property (p_idl) else $error("bad idle entry");
  property p_cpu;
    o_state == PMCS_IDLE ##1 o_state == PMCS_IDLE |-> !o_cpu_tick;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu tick in idle");
  property p_dly;
    dly <= CPU_READY_CYC + 1;
  endproperty
  a_dly: assert property (p_dly) else $error("ready delay long");
  c_sw: cover property (o_state == PMCS_SW_NEW ##1 o_state == PMCS_RUN);
  c_idl: cover property (o_state == PMCS_IDLE ##1 o_state == PMCS_DELAY);
  c_slp: cover property (o_state == PMCS_SLEEP);
endmodule

bind pmcs_switch pmcs_switch_monitor #(.CPU_READY_CYC(CPU_READY_CYC)) mon_u (
  .i_clk, .i_rst, .i_clock_source_select, .i_idle_select, .i_sleep,
  .o_cpu_tick, .o_pri_osc_en, .o_primary_clock_running,
  .o_secondary_clock_active, .o_osc_status, .o_timer_status, .o_state
);

// >>> dv/pmcs_switch_tb.sv
// Self-checking bench for the power mode clock switch
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module pmcs_switch_tb;
  import pmcs_pkg::*;
  localparam int CY = 3;
  logic        i_clk, i_rst, i_idle_select, i_secondary_osc_enable, i_sleep;
  logic        i_two_speed_en, i_fail_safe_en, i_watchdog_en, i_wake_irq;
  logic        i_watchdog_timeout, i_pri_tick, i_sec_tick, i_rc_tick;
  logic        i_pri_ready, i_sec_running, o_cpu_tick, o_periph_tick;
  logic        o_pri_osc_en, o_sec_osc_en, o_rc_osc_en;
  logic        o_primary_clock_running, o_secondary_clock_active;
  logic [1:0]  i_clock_source_select;
  logic [7:0]  o_osc_status, o_timer_status;
  logic [2:0]  tkv;
  pmcs_state_t o_state, ps;
  int          bad_count, n_compared, cyc, n_old, n_new, nc, np, nd;
  int          old_i, new_i, ep, es, t;
  pmcs_switch #(.CPU_READY_CYC(CY)) dut_u (
    .i_clk, .i_rst, .i_clock_source_select, .i_idle_select,
    .i_secondary_osc_enable, .i_sleep, .i_two_speed_en, .i_fail_safe_en,
    .i_watchdog_en, .i_wake_irq, .i_watchdog_timeout, .i_pri_tick,
    .i_sec_tick, .i_rc_tick, .i_pri_ready, .i_sec_running, .o_cpu_tick,
    .o_periph_tick, .o_pri_osc_en, .o_sec_osc_en, .o_rc_osc_en,
    .o_primary_clock_running, .o_secondary_clock_active, .o_osc_status,
    .o_timer_status, .o_state
  );
  assign tkv = {i_rc_tick, i_sec_tick, i_pri_tick};
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  ////////////////////////////////////////
  // A stopped secondary oscillator gives no ticks
  always @(negedge i_clk) begin
    i_pri_tick <= 1'($urandom % 2);
    i_sec_tick <= i_sec_running && ($urandom % 3 == 0);
    i_rc_tick <= 1'($urandom % 2);
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 4000) begin
      bad_count++;
      close_out();
    end else begin
      if (o_state == PMCS_SW_OLD && tkv[old_i]) n_old++;
      if (o_state == PMCS_SW_NEW && tkv[new_i]) n_new++;
      if (o_state == PMCS_DELAY) nd++;
      // First idle cycle may still carry a tick from run
      if (o_state == PMCS_IDLE && ps == PMCS_IDLE) begin
        nc += o_cpu_tick;
        np += o_periph_tick;
      end
      ps = o_state;
    end
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic nx(int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic pulse(ref logic x);
    x = 1'h1;
    nx(1);
    x = 1'h0;
  endtask
  task automatic wait_st(pmcs_state_t s);
    int k;
    k = 0;
    while (o_state !== s && k < 300) begin
      nx(1);
      k++;
    end
    `CHK("state", s, o_state)
  endtask
  task automatic chk_all();
    logic [7:0] xo, xt;
    xo = {i_idle_select, 3'h0, 1'(ep), 1'h0, i_clock_source_select};
    xt = {1'h0, 1'(es), 6'h0};
    `CHK("pri", 1'(ep), o_primary_clock_running)
    `CHK("sec", 1'(es), o_secondary_clock_active)
    `CHK("osc", xo, o_osc_status)
    `CHK("tmr", xt, o_timer_status)
    t++;
    $display("test %0d done", t);
  endtask
  task automatic go(logic [1:0] s, int o, int n);
    old_i = o;
    new_i = n;
    n_old = 0;
    n_new = 0;
    i_clock_source_select = s;
  endtask
  task automatic fin_sw(int p, int q);
    if (o_state !== PMCS_SW_NEW) wait_st(PMCS_SW_OLD);
    wait_st(PMCS_RUN);
    ep = p;
    es = q;
    `CHK("old", 2, n_old)
    `CHK("new", 3, n_new)
    chk_all();
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(59351));
    {i_rst, i_watchdog_en, i_pri_ready, i_sec_running} = 4'hf;
    {i_idle_select, i_secondary_osc_enable, i_sleep, i_two_speed_en} = 4'h0;
    {i_fail_safe_en, i_wake_irq, i_watchdog_timeout} = 3'h0;
    {i_pri_tick, i_sec_tick, i_rc_tick} = 3'h0;
    i_clock_source_select = 2'h2;
    {bad_count, n_compared, cyc, t, es, nc, np, nd} = '0;
    ep = 1;
    nx(3);
    i_rst = 1'h0;
    nx(2);
    chk_all();
    `CHK("pri_en", 1'h1, o_pri_osc_en)
    go(2'h1, 0, 1);
    nx(20);
    `CHK("refuse", PMCS_RUN, o_state)
    chk_all();
    i_clock_source_select = 2'h2;
    nx(2);
    // Secondary chosen before it oscillates
    {i_secondary_osc_enable, i_sec_running} = 2'h2;
    go(2'h1, 0, 1);
    wait_st(PMCS_SW_NEW);
    nx(10);
    `CHK("hold", PMCS_SW_NEW, o_state)
    i_sec_running = 1'h1;
    fin_sw(0, 1);
    `CHK("pri_en", 1'h0, o_pri_osc_en)
    i_pri_ready = 1'h0;
    go(2'h2, 1, 0);
    nx(10);
    `CHK("warm", PMCS_RUN, o_state)
    `CHK("sec", 1'h1, o_secondary_clock_active)
    i_pri_ready = 1'h1;
    fin_sw(1, 0);
    `CHK("sec_en", 1'h1, o_sec_osc_en)
    go(2'h3, 0, 2);
    fin_sw(0, 0);
    `CHK("pri_en", 1'h0, o_pri_osc_en)
    // A cleared select also stays on the RC source
    i_clock_source_select = 2'h0;
    nx(5);
    `CHK("rc0", PMCS_RUN, o_state)
    chk_all();
    i_pri_ready = 1'h0;
    go(2'h2, 2, 0);
    nx(10);
    `CHK("warm", PMCS_RUN, o_state)
    i_pri_ready = 1'h1;
    fin_sw(1, 0);
    `CHK("rc_en", 1'h1, o_rc_osc_en)
    // Idle select drops right after the sleep edge
    i_idle_select = 1'h1;
    pulse(i_sleep);
    i_idle_select = 1'h0;
    wait_st(PMCS_IDLE);
    {nc, np} = '0;
    nx(20);
    `CHK("cpu", 0, nc)
    `CHK("per", 1, np > 0)
    chk_all();
    nd = 0;
    pulse(i_wake_irq);
    wait_st(PMCS_RUN);
    `CHK("dly", CY + 1, nd)
    chk_all();
    pulse(i_sleep);
    wait_st(PMCS_SLEEP);
    {ep, es} = '0;
    chk_all();
    `CHK("rc_on", 1'h1, o_rc_osc_en)
    `CHK("sec_on", 1'h1, o_sec_osc_en)
    pulse(i_watchdog_timeout);
    wait_st(PMCS_DELAY);
    wait_st(PMCS_RUN);
    `CHK("wdt", 1'h1, o_primary_clock_running)
    ep = 1;
    i_two_speed_en = 1'h1;
    pulse(i_sleep);
    wait_st(PMCS_SLEEP);
    pulse(i_wake_irq);
    wait_st(PMCS_DELAY);
    `CHK("on_rc", 1'h0, o_primary_clock_running)
    go(2'h2, 2, 0);
    fin_sw(1, 0);
    // Fail-safe alone keeps the RC source and wakes on it
    {i_two_speed_en, i_fail_safe_en, i_watchdog_en} = 3'h2;
    pulse(i_sleep);
    wait_st(PMCS_SLEEP);
    `CHK("fs_rc", 1'h1, o_rc_osc_en)
    pulse(i_wake_irq);
    wait_st(PMCS_DELAY);
    `CHK("fs_wake", 1'h0, o_primary_clock_running)
    go(2'h2, 2, 0);
    fin_sw(1, 0);
    {i_two_speed_en, i_fail_safe_en} = 2'h2;
    nx(2);
    `CHK("rc_off", 1'h0, o_rc_osc_en)
    i_rst = 1'h1;
    nx(2);
    i_rst = 1'h0;
    nx(1);
    `CHK("ts_rst", 1'h0, o_primary_clock_running)
    close_out();
  end
endmodule
